// ===== logic/can_cmd_top.sv
// command handler for uudt response queries and the can transmit queue
`timescale 1ns/1ps
// Functional notes
// - incoming uudt responses go into their own per-channel store
// - opcode A7 queries uudt store; byte 0 picks channel, bytes 1-3 ignored
// - reply: channel, reserved, returned count, pending count, then 12-byte entries
// - entry: length byte, overflow bit 0 of byte 1, reserved, eight data bytes
// - uudt data kept exactly as received, no service code added
// - uudt capture runs independently of any other diagnostic traffic
// - queued messages leave one by one as the can controller accepts them
// - B1 sends message at once when idle, otherwise appends it
// - message record: id bytes 0-3, length byte 4, data bytes 8-15
// - B2 treats every record like B1: sent at once when idle, otherwise appended
// - B2 carries a 32-bit count then that many 16-byte records
// - B3 reports the transmit queue state
// - state reply: unused slots in bytes 0-3, occupied in 4-7
module can_cmd_top
	import can_cmd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_first_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	output logic rsp_last_o,
	input wire logic rsp_ready_i,
	input wire logic uudt_valid_i,
	input wire logic [CH_W-1:0] uudt_chan_i,
	input wire logic [3:0] uudt_dlc_i,
	input wire logic [63:0] uudt_data_i,
	output logic tx_valid_o,
	output logic [31:0] tx_id_o,
	output logic [3:0] tx_dlc_o,
	output logic [63:0] tx_data_o,
	input wire logic tx_ready_i
);
	state_type state_r;
	state_type state_nxt;
	logic [7:0] idx_r;
	logic [7:0] chan_r;
	logic [31:0] items_r;
	logic [31:0] rec_id_r;
	logic [3:0] rec_dlc_r;
	logic [63:0] rec_data_r;
	logic [7:0] rsp_cnt_r;
	logic [7:0] rsp_len_r;
	logic [7:0] ent_off_r;
	logic [15:0] f0_r;
	logic [15:0] f4_r;
	logic [15:0] f6_r;
	logic [31:0] q_id [TXQ_DEPTH];
	logic [3:0] q_dlc [TXQ_DEPTH];
	logic [63:0] q_data [TXQ_DEPTH];
	logic [TPTR_W-1:0] q_wp_r;
	logic [TPTR_W-1:0] q_rp_r;
	logic [TCNT_W-1:0] q_cnt_r;
	uudt_if ubus ();

	uudt_store uudt_store_inst (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.bus(ubus)
	);

	assign ubus.wr_valid = uudt_valid_i;
	assign ubus.wr_chan = uudt_chan_i;
	assign ubus.wr_dlc = uudt_dlc_i;
	assign ubus.wr_data = uudt_data_i;
	assign ubus.rd_chan = chan_r[CH_W-1:0];

	wire acc = cmd_valid_i && cmd_ready_o;
	wire op_acc = acc && cmd_first_i && (state_r == S_IDLE);
	wire byte_acc = acc && (state_r != S_IDLE);
	wire in_hdr = (state_r == S_UUDT_HDR);
	wire in_cnt = (state_r == S_COUNT);
	wire in_rec = (state_r == S_RECORD);
	wire txq_rst = op_acc && (cmd_data_i == OP_TXQ_RESET);
	wire start_state = op_acc && (cmd_data_i == OP_TXQ_STATE);
	wire start_uudt = byte_acc && in_hdr && (idx_r == UUDT_CMD_LAST);
	wire [31:0] cnt_word = {cmd_data_i, items_r[31:8]};
	wire cnt_done = byte_acc && in_cnt && (idx_r == CNT_LAST);
	wire rec_done = byte_acc && in_rec && (idx_r == REC_LAST);
	wire [63:0] rec_data_w = {cmd_data_i, rec_data_r[63:8]};
	wire [3:0] dlc_in = (cmd_data_i > DLC_MAX) ? DLC_MAX[3:0] : cmd_data_i[3:0];
	wire tx_done = tx_valid_o && tx_ready_i;
	wire direct = rec_done && !tx_valid_o && (q_cnt_r == 5'h00);
	wire push = rec_done && !direct && (q_cnt_r != TXQ_FULL);
	wire q_pop = !direct && (!tx_valid_o || tx_done) && (q_cnt_r != 5'h00);
	wire [TCNT_W-1:0] q_cnt_nxt = txq_rst ? 5'h00 : (q_cnt_r + {4'h0, push} - {4'h0, q_pop});
	wire chan_ok = (chan_r < 8'(CH_NUM));
	wire [7:0] cnt8 = chan_ok ? {4'h0, ubus.head_cnt} : 8'h00;
	wire [7:0] n_w = (cnt8 > MAX_RET) ? MAX_RET : cnt8;
	wire [7:0] rem_w = cnt8 - n_w;
	wire [4:0] unused_w = TXQ_FULL - q_cnt_r;
	wire rsp_take = (state_r == S_REPLY) && (!rsp_valid_o || rsp_ready_i);
	wire rsp_load = rsp_take && (rsp_cnt_r != rsp_len_r);
	wire is_ent = (rsp_cnt_r >= HDR_BYTES);
	wire ent_end = (ent_off_r == ENT_LAST);
	wire [63:0] ent_shift = ubus.head_data >> {ent_off_r - ENT_DATA_FIRST, 3'b000};
	wire [7:0] ent_byte = (ent_off_r == 8'h00) ? {4'h0, ubus.head_dlc} :
		(ent_off_r == ENT_FLAG_POS) ? {7'h00, ubus.head_ovf} :
		(ent_off_r >= ENT_DATA_FIRST) ? ent_shift[7:0] : 8'h00;
	wire [7:0] hdr_byte = (rsp_cnt_r == 8'h00) ? f0_r[7:0] :
		(rsp_cnt_r == 8'h01) ? f0_r[15:8] :
		(rsp_cnt_r == 8'h04) ? f4_r[7:0] :
		(rsp_cnt_r == 8'h05) ? f4_r[15:8] :
		(rsp_cnt_r == 8'h06) ? f6_r[7:0] :
		(rsp_cnt_r == 8'h07) ? f6_r[15:8] : 8'h00;
	wire [7:0] rsp_byte = is_ent ? ent_byte : hdr_byte;
	assign ubus.rd_pop = rsp_load && is_ent && ent_end;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:
			begin
				if (op_acc)
				begin
					case (cmd_data_i)
						OP_UUDT_QUERY: state_nxt = S_UUDT_HDR;
						OP_TXQ_ONE: state_nxt = S_RECORD;
						OP_TXQ_MANY: state_nxt = S_COUNT;
						OP_TXQ_STATE: state_nxt = S_REPLY;
						default: state_nxt = S_IDLE;
					endcase
				end
			end
			S_UUDT_HDR: if (start_uudt) state_nxt = S_REPLY;
			S_COUNT: if (cnt_done) state_nxt = (cnt_word == 32'h0) ? S_IDLE : S_RECORD;
			S_RECORD: if (rec_done && (items_r == 32'h1)) state_nxt = S_IDLE;
			S_REPLY: if (rsp_take && !rsp_load) state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= S_IDLE;
			cmd_ready_o <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cmd_ready_o <= (state_nxt != S_REPLY) && (q_cnt_nxt < TXQ_READY_LIMIT);
		end
	end
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || op_acc || start_uudt || cnt_done || rec_done)
			idx_r <= 8'h00;
		else if (byte_acc)
			idx_r <= idx_r + 8'h01;
	end
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			chan_r <= 8'h00;
		else if (byte_acc && in_hdr && (idx_r == 8'h00))
			chan_r <= cmd_data_i;
	end
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			items_r <= 32'h0;
		else if (op_acc)
			items_r <= 32'h1;
		else if (byte_acc && in_cnt)
			items_r <= cnt_word;
		else if (rec_done)
			items_r <= items_r - 32'h1;
	end
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rec_id_r <= 32'h0;
			rec_dlc_r <= 4'h0;
			rec_data_r <= 64'h0;
		end
		else if (byte_acc && in_rec)
		begin
			if (idx_r <= REC_ID_LAST)
				rec_id_r <= {cmd_data_i, rec_id_r[31:8]};
			if (idx_r == REC_DLC_POS)
				rec_dlc_r <= dlc_in;
			if (idx_r >= REC_DATA_FIRST)
				rec_data_r <= rec_data_w;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			f0_r <= 16'h0;
			f4_r <= 16'h0;
			f6_r <= 16'h0;
			rsp_len_r <= 8'h00;
		end
		else if (start_state)
		begin
			f0_r <= {11'h000, unused_w};
			f4_r <= {11'h000, q_cnt_r};
			f6_r <= 16'h0;
			rsp_len_r <= STATE_BYTES;
		end
		else if (start_uudt)
		begin
			f0_r <= {8'h00, chan_r};
			f4_r <= {8'h00, n_w};
			f6_r <= {8'h00, rem_w};
			rsp_len_r <= HDR_BYTES + ENTRY_BYTES * n_w;
		end
	end
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || start_state || start_uudt)
		begin
			rsp_cnt_r <= 8'h00;
			ent_off_r <= 8'h00;
		end
		else if (rsp_load)
		begin
			rsp_cnt_r <= rsp_cnt_r + 8'h01;
			if (is_ent)
				ent_off_r <= ent_end ? 8'h00 : ent_off_r + 8'h01;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 8'h00;
			rsp_last_o <= 1'b0;
		end
		else if (rsp_load)
		begin
			rsp_valid_o <= 1'b1;
			rsp_data_o <= rsp_byte;
			rsp_last_o <= (rsp_cnt_r + 8'h01 == rsp_len_r);
		end
		else if (rsp_take)
		begin
			rsp_valid_o <= 1'b0;
			rsp_last_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (push)
		begin
			q_id[q_wp_r] <= rec_id_r;
			q_dlc[q_wp_r] <= rec_dlc_r;
			q_data[q_wp_r] <= rec_data_w;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || txq_rst)
		begin
			q_wp_r <= 4'h0;
			q_rp_r <= 4'h0;
		end
		else
		begin
			if (push)
				q_wp_r <= q_wp_r + 4'h1;
			if (q_pop)
				q_rp_r <= q_rp_r + 4'h1;
		end
		q_cnt_r <= sys_rst_i ? 5'h00 : q_cnt_nxt;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || txq_rst)
		begin
			tx_valid_o <= 1'b0;
			tx_id_o <= 32'h0;
			tx_dlc_o <= 4'h0;
			tx_data_o <= 64'h0;
		end
		else if (direct)
		begin
			tx_valid_o <= 1'b1;
			tx_id_o <= rec_id_r;
			tx_dlc_o <= rec_dlc_r;
			tx_data_o <= rec_data_w;
		end
		else if (q_pop)
		begin
			tx_valid_o <= 1'b1;
			tx_id_o <= q_id[q_rp_r];
			tx_dlc_o <= q_dlc[q_rp_r];
			tx_data_o <= q_data[q_rp_r];
		end
		else if (tx_done)
			tx_valid_o <= 1'b0;
	end

	a_direct_send: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		direct |=> tx_valid_o && (tx_id_o == $past(rec_id_r)) && (q_cnt_r == 5'h00))
		else $error("idle message not sent at once");
	a_busy_append: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(rec_done && tx_valid_o && !tx_done && (q_cnt_r < TXQ_FULL)) |=> (q_cnt_r == $past(q_cnt_r) + 5'h01))
		else $error("message not appended while busy");
	a_reset_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		txq_rst |=> !tx_valid_o && (q_cnt_r == 5'h00) && (q_wp_r == q_rp_r))
		else $error("queue reset incomplete");
	a_tx_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(tx_valid_o && !tx_ready_i && !txq_rst) |=> tx_valid_o && $stable(tx_id_o) && $stable(tx_data_o))
		else $error("pending message changed before acceptance");
	a_state_fields: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		start_state |=> (f0_r + f4_r == 16'h0010) && (rsp_len_r == STATE_BYTES))
		else $error("queue state fields inconsistent");
	a_reply_length: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		start_uudt |=> (rsp_len_r == HDR_BYTES + ENTRY_BYTES * f4_r[7:0]) && (f4_r <= 16'h0004))
		else $error("uudt reply length wrong");
	a_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(rsp_load && ((rsp_cnt_r == 8'h02) || (rsp_cnt_r == 8'h03))) |=> rsp_valid_o && (rsp_data_o == 8'h00))
		else $error("reserved reply byte not zero");
	a_entry_flags: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(rsp_load && is_ent && (ent_off_r == ENT_FLAG_POS)) |=> (rsp_data_o[7:1] == 7'h00))
		else $error("entry flag byte has reserved bits set");
	a_entry_pop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(ubus.rd_pop) |-> is_ent && ((rsp_cnt_r - HDR_BYTES) % ENTRY_BYTES == ENT_LAST))
		else $error("entry popped at wrong byte");
endmodule

// ===== logic/can_cmd_pkg.sv
// constants and types for the can command handler
package can_cmd_pkg;
	localparam logic [7:0] OP_UUDT_QUERY = 8'hA7;
	localparam logic [7:0] OP_TXQ_RESET = 8'hB0;
	localparam logic [7:0] OP_TXQ_ONE = 8'hB1;
	localparam logic [7:0] OP_TXQ_MANY = 8'hB2;
	localparam logic [7:0] OP_TXQ_STATE = 8'hB3;
	localparam int CH_NUM = 4;
	localparam int CH_W = 2;
	localparam logic [3:0] UUDT_DEPTH = 4'h8;
	localparam int UPTR_W = 3;
	localparam int UCNT_W = 4;
	localparam int TXQ_DEPTH = 16;
	localparam int TPTR_W = 4;
	localparam int TCNT_W = 5;
	localparam logic [4:0] TXQ_FULL = 5'h10;
	localparam logic [4:0] TXQ_READY_LIMIT = 5'h0F;
	localparam logic [7:0] UUDT_CMD_LAST = 8'h03;
	localparam logic [7:0] CNT_LAST = 8'h03;
	localparam logic [7:0] REC_ID_LAST = 8'h03;
	localparam logic [7:0] REC_DLC_POS = 8'h04;
	localparam logic [7:0] REC_DATA_FIRST = 8'h08;
	localparam logic [7:0] REC_LAST = 8'h0F;
	localparam logic [7:0] HDR_BYTES = 8'h08;
	localparam logic [7:0] STATE_BYTES = 8'h08;
	localparam logic [7:0] ENTRY_BYTES = 8'h0C;
	localparam logic [7:0] ENT_FLAG_POS = 8'h01;
	localparam logic [7:0] ENT_DATA_FIRST = 8'h04;
	localparam logic [7:0] ENT_LAST = 8'h0B;
	localparam logic [7:0] MAX_RET = 8'h04;
	localparam logic [7:0] DLC_MAX = 8'h08;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_UUDT_HDR = 3'b001,
		S_COUNT = 3'b010,
		S_RECORD = 3'b011,
		S_REPLY = 3'b100
	} state_type;
endpackage

// ===== logic/uudt_if.sv
// link between the command handler and the uudt response store
`timescale 1ns/1ps
interface uudt_if;
	import can_cmd_pkg::*;
	logic wr_valid;
	logic [CH_W-1:0] wr_chan;
	logic [3:0] wr_dlc;
	logic [63:0] wr_data;
	logic [CH_W-1:0] rd_chan;
	logic rd_pop;
	logic [3:0] head_dlc;
	logic head_ovf;
	logic [63:0] head_data;
	logic [UCNT_W-1:0] head_cnt;
	modport owner (output wr_valid, wr_chan, wr_dlc, wr_data, rd_chan, rd_pop,
		input head_dlc, head_ovf, head_data, head_cnt);
	modport store (input wr_valid, wr_chan, wr_dlc, wr_data, rd_chan, rd_pop,
		output head_dlc, head_ovf, head_data, head_cnt);
endinterface

// ===== logic/uudt_store.sv
// per-channel store of uudt diagnostic responses
`timescale 1ns/1ps
module uudt_store
	import can_cmd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	uudt_if.store bus
);
	logic [3:0] dlc_mem [CH_NUM*8];
	logic [63:0] data_mem [CH_NUM*8];
	logic [UPTR_W-1:0] wp_a [CH_NUM];
	logic [UPTR_W-1:0] rp_a [CH_NUM];
	logic [UCNT_W-1:0] cnt_a [CH_NUM];
	logic ovf_a [CH_NUM];
	logic [CH_NUM-1:0] wr_ok_a;
	wire [CH_W+UPTR_W-1:0] wr_addr = {bus.wr_chan, wp_a[bus.wr_chan]};
	wire [CH_W+UPTR_W-1:0] rd_addr = {bus.rd_chan, rp_a[bus.rd_chan]};
	assign bus.head_dlc = dlc_mem[rd_addr];
	assign bus.head_data = data_mem[rd_addr];
	assign bus.head_ovf = ovf_a[bus.rd_chan];
	assign bus.head_cnt = cnt_a[bus.rd_chan];

	always_ff @(posedge mclk_i)
	begin
		if (|wr_ok_a)
		begin
			dlc_mem[wr_addr] <= bus.wr_dlc;
			data_mem[wr_addr] <= bus.wr_data;
		end
	end

	genvar c;
	generate
		for (c = 0; c < CH_NUM; c++)
		begin : g_ch
			logic [UPTR_W-1:0] wp_r;
			logic [UPTR_W-1:0] rp_r;
			logic [UCNT_W-1:0] cnt_r;
			logic ovf_r;
			wire wr_hit = bus.wr_valid && (bus.wr_chan == CH_W'(c));
			wire full = (cnt_r == UUDT_DEPTH);
			wire wr_ok = wr_hit && !full;
			wire pop_hit = bus.rd_pop && (bus.rd_chan == CH_W'(c)) && (cnt_r != 4'h0);
			assign wr_ok_a[c] = wr_ok;
			assign wp_a[c] = wp_r;
			assign rp_a[c] = rp_r;
			assign cnt_a[c] = cnt_r;
			assign ovf_a[c] = ovf_r;
			always_ff @(posedge mclk_i)
			begin
				if (sys_rst_i)
				begin
					wp_r <= 3'h0;
					rp_r <= 3'h0;
					cnt_r <= 4'h0;
					ovf_r <= 1'b0;
				end
				else
				begin
					if (wr_ok)
						wp_r <= wp_r + 3'h1;
					if (pop_hit)
						rp_r <= rp_r + 3'h1;
					cnt_r <= cnt_r + {3'h0, wr_ok} - {3'h0, pop_hit};
					if (wr_hit && full)
						ovf_r <= 1'b1;
					else if (pop_hit)
						ovf_r <= 1'b0;
				end
			end
			a_loss_marks_ovf: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				(wr_hit && full) |=> ovf_r && (cnt_r == UUDT_DEPTH - {3'h0, $past(pop_hit)}))
				else $error("lost uudt response not flagged");
			a_store_counts: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				(wr_ok && !pop_hit) |=> (cnt_r == $past(cnt_r) + 4'h1) && (wp_r == $past(wp_r) + 3'h1))
				else $error("uudt response not stored");
		end
	endgenerate
endmodule

// ===== test/can_ctrl_model.sv
// can controller stand-in that takes offered messages
`timescale 1ns/1ps
module can_ctrl_model
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic stall_i,
	input wire logic slow_i,
	output logic tx_ready_o
);
	logic [1:0] pace_r;
	always_ff @(posedge mclk_i)
	begin
		pace_r <= sys_rst_i ? 2'h0 : pace_r + 2'h1;
		tx_ready_o <= !sys_rst_i && !stall_i && (!slow_i || pace_r == 2'h0);
	end
endmodule

// ===== test/can_uudt_buffer_and_tx_queue_test.sv
// self-checking bench for the can command handler
`timescale 1ns/1ps
module can_uudt_buffer_and_tx_queue_test;
	import can_cmd_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic cmd_first_i = 1'b0;
	logic [7:0] cmd_data_i = 8'h00;
	logic rsp_ready_i = 1'b0;
	logic uudt_valid_i = 1'b0;
	logic [CH_W-1:0] uudt_chan_i = '0;
	logic [3:0] uudt_dlc_i = 4'h0;
	logic [63:0] uudt_data_i = 64'h0;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic cmd_ready_o, rsp_valid_o, rsp_last_o, tx_valid_o, tx_ready_i;
	logic [7:0] rsp_data_o;
	logic [31:0] tx_id_o;
	logic [3:0] tx_dlc_o;
	logic [63:0] tx_data_o;
	logic [8:0] rsp_q[$];
	logic [99:0] tx_q[$];
	logic [67:0] uq[CH_NUM][$];
	logic [3:0] ovf = 4'h0;
	logic [2:0] cyc = 3'h0;
	logic [31:0] seed = 32'h7B83;
	int miscompares = 0;
	int compares = 0;

	can_cmd_top can_cmd_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_first_i(cmd_first_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_last_o(rsp_last_o),
		.rsp_ready_i(rsp_ready_i), .uudt_valid_i(uudt_valid_i), .uudt_chan_i(uudt_chan_i),
		.uudt_dlc_i(uudt_dlc_i), .uudt_data_i(uudt_data_i), .tx_valid_o(tx_valid_o), .tx_id_o(tx_id_o),
		.tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
	can_ctrl_model can_ctrl_model_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
		.slow_i(slow), .tx_ready_o(tx_ready_i));

	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 3'h1;
		rsp_ready_i <= (cyc != 3'h5);
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input string what, input logic [99:0] seen, input logic [99:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task put(input logic [7:0] b, input logic f);
		int n;
		n = 0;
		cmd_valid_i <= 1'b1;
		cmd_first_i <= f;
		cmd_data_i <= b;
		@(negedge mclk_i);
		while (cmd_ready_o !== 1'b1 && n < 2000)
		begin
			@(negedge mclk_i);
			n++;
		end
		if (n == 2000)
		begin
			miscompares++;
			test_done();
		end
		@(posedge mclk_i);
	endtask
	task fin();
		cmd_valid_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task junk(input int k);
		logic [31:0] r;
		repeat (k)
		begin
			r = rnd();
			put(r[7:0], 1'b0);
		end
	endtask
	task ex(input logic [7:0] b, input logic l);
		rsp_q.push_back({l, b});
	endtask
	task rec(input logic [31:0] id, input logic [7:0] dlc, input logic [63:0] d, input logic e);
		int i;
		for (i = 0; i < 4; i++) put(id[8*i+:8], 1'b0);
		put(dlc, 1'b0);
		junk(3);
		for (i = 0; i < 8; i++) put(d[8*i+:8], 1'b0);
		if (e) tx_q.push_back({id, (dlc > DLC_MAX) ? 4'h8 : dlc[3:0], d});
	endtask
	task one(input logic [7:0] dlc);
		put(OP_TXQ_ONE, 1'b1);
		rec(rnd(), dlc, {rnd(), rnd()}, 1'b1);
		fin();
	endtask
	task many(input int n, input logic e);
		int i;
		logic [31:0] c;
		c = n;
		put(OP_TXQ_MANY, 1'b1);
		for (i = 0; i < 4; i++) put(c[8*i+:8], 1'b0);
		for (i = 0; i < n; i++) rec(rnd(), 8'(rnd() % 9), {rnd(), rnd()}, e);
		fin();
	endtask
	task zap();
		put(OP_TXQ_RESET, 1'b1);
		junk(4);
		fin();
	endtask
	task state(input logic [7:0] used);
		logic [7:0] u;
		u = 8'h10 - used;
		ex(u, 0); ex(8'h00, 0); ex(8'h00, 0); ex(8'h00, 0);
		ex(used, 0); ex(8'h00, 0); ex(8'h00, 0); ex(8'h00, 1);
		put(OP_TXQ_STATE, 1'b1);
		fin();
		@(negedge mclk_i);
		check("ready in reply", 100'(cmd_ready_o), 100'h0);
		@(posedge mclk_i);
	endtask
	task query(input logic [7:0] ch);
		int s, n, i, k;
		logic [67:0] e;
		logic [1:0] c;
		c = ch[1:0];
		s = (ch < 8'h04) ? uq[c].size() : 0;
		n = (s > 4) ? 4 : s;
		ex(ch, 0); ex(8'h00, 0); ex(8'h00, 0); ex(8'h00, 0);
		ex(8'(n), 0); ex(8'h00, 0); ex(8'(s - n), 0); ex(8'h00, n == 0);
		for (k = 0; k < n; k++)
		begin
			e = uq[c].pop_front();
			ex({4'h0, e[67:64]}, 0);
			ex({7'h00, ovf[c]}, 0);
			ovf[c] = 1'b0;
			ex(8'h00, 0); ex(8'h00, 0);
			for (i = 0; i < 8; i++) ex(e[8*i+:8], k == n - 1 && i == 7);
		end
		put(OP_UUDT_QUERY, 1'b1);
		put(ch, 1'b0);
		junk(3);
		fin();
	endtask
	task inj(input logic [1:0] ch, input int k);
		logic [3:0] d;
		logic [63:0] v;
		repeat (k)
		begin
			d = 4'(rnd() % 9);
			v = {rnd(), rnd()};
			uudt_valid_i <= 1'b1;
			uudt_chan_i <= ch;
			uudt_dlc_i <= d;
			uudt_data_i <= v;
			if (uq[ch].size() < 8) uq[ch].push_back({d, v});
			else ovf[ch] = 1'b1;
			@(posedge mclk_i);
		end
		uudt_valid_i <= 1'b0;
	endtask
	task drain();
		int n;
		n = 0;
		while ((rsp_q.size() > 0 || tx_q.size() > 0) && n < 5000)
		begin
			@(posedge mclk_i);
			n++;
		end
		if (n == 5000)
		begin
			miscompares++;
			test_done();
		end
	endtask

	always @(negedge mclk_i)
	begin
		if (rsp_valid_o === 1'b1 && rsp_ready_i)
		begin
			if (rsp_q.size() == 0) check("reply extra", 100'(rsp_data_o), 100'h1FF);
			else check("reply byte", 100'({rsp_last_o, rsp_data_o}), 100'(rsp_q.pop_front()));
		end
		if (tx_valid_o === 1'b1 && tx_ready_i)
		begin
			if (tx_q.size() == 0) check("tx extra", {tx_id_o, tx_dlc_o, tx_data_o}, 100'h0);
			else check("tx message", {tx_id_o, tx_dlc_o, tx_data_o}, tx_q.pop_front());
		end
	end

	initial
	begin
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		zap();
		state(8'h00);
		one(8'h05);
		one(8'h0C);
		many(0, 1'b1);
		drain();
		$display("test single done");
		stall <= 1'b1;
		many(5, 1'b1);
		repeat (6) @(posedge mclk_i);
		state(8'h04);
		stall <= 1'b0;
		slow <= 1'b1;
		drain();
		$display("test queued done");
		stall <= 1'b1;
		many(3, 1'b0);
		zap();
		stall <= 1'b0;
		state(8'h00);
		drain();
		$display("test queue reset done");
		fork
			one(8'h08);
			begin
				repeat (6) @(posedge mclk_i);
				inj(2'h1, 3);
			end
		join
		query(8'h01);
		inj(2'h2, 10);
		query(8'h02);
		query(8'h02);
		query(8'h00);
		query(8'h05);
		drain();
		$display("test uudt done");
		test_done();
	end
endmodule
